// ### uart_control_error_status_tb_top.sv
// self-checking bench for the uart control and error status block
// assumes uce_params.svh on the include path and the remote device model
`timescale 1ns/1ps
`include "uce_params.svh"

module uart_control_error_status_tb_top
  import uce_pkg::*;
;
  logic            clk;
  logic            rst;
  uce_req_type     req;
  uce_rx_char_type rx;
  logic            rx_brk;
  logic            fifo_full;
  logic            tx_busy;
  logic            rsp_valid;
  logic            tx_en;
  logic            rx_en;
  logic            hdx;
  logic            hw_en;
  logic            tx_allow;
  logic            rx_push;
  logic [15:0]     rdata;
  logic [15:0]     link_st;
  logic [8:0]      rx_data;
  int              errors;
  int              n_compared;
  int              seed;
  logic [31:0]     r;
  // bench model state
  logic [1:0]      m_en;
  logic [3:0]      m_flow;
  logic [3:0]      m_flags;
  logic [7:0]      m_res;
  logic [7:0]      m_sus;
  logic [15:0]     m_link;
  logic            m_run;
  logic            m_match;
  logic [11:0]     ofs [6] = '{`UCE_OFS_ENABLE, `UCE_OFS_FLOW, `UCE_OFS_RESUME,
                               `UCE_OFS_SUSPEND, `UCE_OFS_ERR, 12'h00A};
  logic [8:0]      adr_seq [7] = '{9'h041, 9'h121, 9'h042, 9'h150, 9'h043, 9'h17E, 9'h044};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  uce_ctrl dut_u (
    .i_core_clk     (clk),
    .i_rst          (rst),
    .i_req          (req),
    .o_rsp_valid    (rsp_valid),
    .o_rsp_rdata    (rdata),
    .i_rx           (rx),
    .i_rx_break     (rx_brk),
    .i_rx_fifo_full (fifo_full),
    .i_tx_busy      (tx_busy),
    .o_tx_en        (tx_en),
    .o_rx_en        (rx_en),
    .o_half_duplex  (hdx),
    .o_hw_flow_en   (hw_en),
    .o_tx_allow     (tx_allow),
    .o_rx_push      (rx_push),
    .o_rx_data      (rx_data),
    .o_link_state   (link_st)
  );

  uce_remote_dev rdev_u (
    .i_core_clk (clk),
    .o_rx       (rx),
    .o_rx_break (rx_brk)
  );

  // =====================================================================
  // compare and report
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_rd(input logic lnk, input logic [11:0] a);
    if (lnk) return m_link;
    case (a)
      `UCE_OFS_ENABLE:  return {14'h0, m_en};
      `UCE_OFS_FLOW:    return {12'h0, m_flow};
      `UCE_OFS_RESUME:  return {8'h0, m_res};
      `UCE_OFS_SUSPEND: return {8'h0, m_sus};
      `UCE_OFS_ERR:     return {8'h0, rx_brk, m_flags, 3'h0};
      default:          return 16'h0000;
    endcase
  endfunction

  // =====================================================================
  // vendor request, answer one cycle later
  task automatic acc(input logic lnk, input logic wr, input logic [11:0] a, input logic [15:0] wd);
    logic [15:0] exp;
    @(posedge clk);
    #1;
    exp = wr ? 16'h0000 : exp_rd(lnk, a);
    // clear before the edge so a same-edge event lands after it
    if (!wr && !lnk && a == `UCE_OFS_ERR) m_flags = {3'h0, rx_brk};
    if (wr && lnk) m_link = wd;
    if (wr && !lnk && a == `UCE_OFS_ENABLE) m_en = wd[1:0];
    if (wr && !lnk && a == `UCE_OFS_RESUME) m_res = wd[7:0];
    if (wr && !lnk && a == `UCE_OFS_SUSPEND) m_sus = wd[7:0];
    if (wr && !lnk && a == `UCE_OFS_FLOW) begin
      m_flow = wd[3:0];
      // gate states survive a rewrite that stays in their own mode
      if (wd[2:0] != `UCE_MODE_SW) m_run = 1'b1;
      if (wd[2:0] != `UCE_MODE_MD_RX && wd[2:0] != `UCE_MODE_MD_ALL) m_match = 1'b0;
    end
    req = '{valid: 1'b1, write: wr, link: lnk, addr: a, wdata: wd};
    @(posedge clk);
    #1 req.valid = 1'b0;
    chk("rsp_valid", 16'h0001, {15'h0, rsp_valid});
    chk("rsp_rdata", exp, rdata);
    chk("config", {12'h0, m_en, m_flow[3], m_flow[2:0] == `UCE_MODE_HW}, {12'h0, rx_en, tx_en, hdx, hw_en});
    chk("link_state", m_link, link_st);
  endtask

  task automatic cfg(input logic [3:0] fl, input logic [7:0] rs, input logic [7:0] sp);
    acc(1'b0, 1'b1, `UCE_OFS_ENABLE, 16'h0000);
    acc(1'b0, 1'b1, `UCE_OFS_FLOW, {12'h0, fl});
    acc(1'b0, 1'b1, `UCE_OFS_RESUME, {8'h0, rs});
    acc(1'b0, 1'b1, `UCE_OFS_SUSPEND, {8'h0, sp});
    acc(1'b0, 1'b1, `UCE_OFS_ENABLE, 16'h0003);
    acc(1'b0, 1'b0, `UCE_OFS_FLOW, 16'h0000);
  endtask

  // =====================================================================
  // received character through the model, checked one cycle later
  task automatic rx_chr(input logic [8:0] d, input logic pe, input logic fe);
    logic       st;
    logic [2:0] md;
    rdev_u.send(d, pe, fe);
    md = m_flow[2:0];
    st = m_en[1] && !(m_flow[3] && tx_busy);
    if (st) m_flags[2:1] = m_flags[2:1] | {pe, fe};
    if (st && md == `UCE_MODE_SW && !d[8] && (d[7:0] == m_res || d[7:0] == m_sus)) begin
      m_run = (d[7:0] == m_res);
      st = 1'b0;
    end
    if (st && (md == `UCE_MODE_MD_RX || md == `UCE_MODE_MD_ALL)) begin
      if (d[8]) m_match = (d[7:0] == m_res) || (d[7:0] == m_sus);
      st = !d[8] && m_match;
    end
    if (st && fifo_full) begin
      m_flags[3] = 1'b1;
      st = 1'b0;
    end
    chk("rx_push", {15'h0, st}, {15'h0, rx_push});
    if (st) chk("rx_data", {7'h0, d}, {7'h0, rx_data});
    if (md == `UCE_MODE_SW || md == `UCE_MODE_MD_ALL)
      chk("tx_allow", {15'h0, m_en[0] && (md == `UCE_MODE_SW ? m_run : m_match)}, {15'h0, tx_allow});
  endtask

  task automatic brk(input logic b);
    rdev_u.set_break(b);
    if (b) m_flags[0] = 1'b1;
  endtask

  // =====================================================================
  // main sequence
  initial begin
    errors = 0;
    n_compared = 0;
    seed = 75;
    rst = 1'b1;
    req = '0;
    fifo_full = 1'b0;
    tx_busy = 1'b0;
    m_en = 2'h0;
    m_flow = 4'h0;
    m_flags = 4'h0;
    m_res = 8'h11;
    m_sus = 8'h13;
    m_link = 16'h0000;
    m_run = 1'b1;
    m_match = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    foreach (ofs[i]) acc(1'b0, 1'b0, ofs[i], 16'h0000);
    acc(1'b1, 1'b0, `UCE_OFS_LINK, 16'h0000);
    acc(1'b1, 1'b1, `UCE_OFS_LINK, 16'hA5C3);
    acc(1'b1, 1'b0, `UCE_OFS_LINK, 16'h0000);
    acc(1'b0, 1'b1, 12'h00A, 16'h1234);
    acc(1'b0, 1'b0, 12'h00A, 16'h0000);
    acc(1'b0, 1'b1, `UCE_OFS_ENABLE, 16'h0002);
    acc(1'b0, 1'b0, `UCE_OFS_ENABLE, 16'h0000);
    acc(1'b0, 1'b1, `UCE_OFS_ENABLE, 16'h0001);
    $display("test register map done");
    cfg(4'h0, 8'h11, 8'h13);
    repeat (6) begin
      r = $random(seed);
      rx_chr({1'b0, r[7:0]}, 1'b0, 1'b0);
    end
    fifo_full = 1'b1;
    rx_chr(9'h055, 1'b0, 1'b0);
    fifo_full = 1'b0;
    rx_chr(9'h056, 1'b1, 1'b0);
    rx_chr(9'h057, 1'b0, 1'b1);
    brk(1'b1);
    acc(1'b0, 1'b0, `UCE_OFS_ERR, 16'h0000);
    acc(1'b0, 1'b0, `UCE_OFS_ERR, 16'h0000);
    brk(1'b0);
    acc(1'b0, 1'b0, `UCE_OFS_ERR, 16'h0000);
    acc(1'b0, 1'b0, `UCE_OFS_ERR, 16'h0000);
    fork
      acc(1'b0, 1'b0, `UCE_OFS_ERR, 16'h0000);
      rx_chr(9'h058, 1'b1, 1'b0);
    join
    acc(1'b0, 1'b0, `UCE_OFS_ERR, 16'h0000);
    $display("test errors done");
    cfg(4'h1, 8'h11, 8'h13);
    rx_chr(9'h0A5, 1'b0, 1'b0);
    cfg(4'h8, 8'h11, 8'h13);
    tx_busy = 1'b1;
    rx_chr(9'h061, 1'b0, 1'b0);
    tx_busy = 1'b0;
    rx_chr(9'h062, 1'b0, 1'b0);
    $display("test duplex done");
    cfg(4'h2, 8'h11, 8'h13);
    rx_chr(9'h013, 1'b0, 1'b0);
    rx_chr(9'h044, 1'b0, 1'b0);
    rx_chr(9'h011, 1'b0, 1'b0);
    cfg(4'h2, 8'h55, 8'h13);
    rx_chr(9'h013, 1'b0, 1'b0);
    rx_chr(9'h155, 1'b0, 1'b0);
    rx_chr(9'h055, 1'b0, 1'b0);
    $display("test software flow done");
    for (int m = 3; m <= 4; m++) begin
      cfg(m[3:0], 8'h21, 8'h7E);
      foreach (adr_seq[i]) rx_chr(adr_seq[i], 1'b0, 1'b0);
    end
    $display("test multidrop done");
    end_sim();
  end

  // sequence needs well under a thousand cycles; generous margin
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule

// ### uce_ctrl.sv
// uart control, flow mode, flow character and error status registers
// assumes requests and receiver events arrive on the core clock domain
`timescale 1ns/1ps
`include "uce_params.svh"

module uce_ctrl
  import uce_pkg::*;
(
  input  wire logic            i_core_clk,
  input  wire logic            i_rst,
  input  wire uce_req_type     i_req,
  output logic                 o_rsp_valid,
  output logic [15:0]          o_rsp_rdata,
  input  wire uce_rx_char_type i_rx,
  input  wire logic            i_rx_break,
  input  wire logic            i_rx_fifo_full,
  input  wire logic            i_tx_busy,
  output logic                 o_tx_en,
  output logic                 o_rx_en,
  output logic                 o_half_duplex,
  output logic                 o_hw_flow_en,
  output logic                 o_tx_allow,
  output logic                 o_rx_push,
  output logic [8:0]           o_rx_data,
  output logic [15:0]          o_link_state
);

  // =====================================================================
  // helpers
  // nine-bit characters never match: the stored bit 8 is taken as zero
  function automatic logic char_match(input logic [8:0] ch, input logic [7:0] ref_chr);
    char_match = (ch == {1'b0, ref_chr});
  endfunction

  function automatic logic reg_hit(input uce_req_type rq, input logic [11:0] ofs);
    reg_hit = rq.valid && !rq.link && (rq.addr == ofs);
  endfunction

  // =====================================================================
  // register state
  logic [1:0]  enable_q,  enable_d;
  logic [3:0]  flow_q,    flow_d;
  logic [7:0]  resume_q,  resume_d;
  logic [7:0]  suspend_q, suspend_d;
  logic [15:0] link_q,    link_d;
  logic        rsp_valid_q, rsp_valid_d;
  logic [15:0] rsp_rdata_q, rsp_rdata_d;
  logic [3:0]  err_flags;
  logic        err_clear;

  always_comb begin
    enable_d  = enable_q;
    flow_d    = flow_q;
    resume_d  = resume_q;
    suspend_d = suspend_q;
    link_d    = link_q;
    if (i_req.valid && i_req.write) begin
      // reserved bits are dropped, so they always read back zero
      if (i_req.link) begin
        if (i_req.addr == `UCE_OFS_LINK) begin
          link_d = i_req.wdata;
        end
      end else if (i_req.addr == `UCE_OFS_ENABLE) begin
        enable_d = i_req.wdata[1:0];
      end else if (i_req.addr == `UCE_OFS_FLOW) begin
        // no interlock against enabled uart; outcome is software's concern
        flow_d = i_req.wdata[3:0];
      end else if (i_req.addr == `UCE_OFS_RESUME) begin
        resume_d = i_req.wdata[7:0];
      end else if (i_req.addr == `UCE_OFS_SUSPEND) begin
        suspend_d = i_req.wdata[7:0];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      enable_q  <= `UCE_RST_ENABLE;
      flow_q    <= `UCE_RST_FLOW;
      resume_q  <= `UCE_RST_RESUME;
      suspend_q <= `UCE_RST_SUSPEND;
      link_q    <= `UCE_RST_LINK;
    end else begin
      enable_q  <= enable_d;
      flow_q    <= flow_d;
      resume_q  <= resume_d;
      suspend_q <= suspend_d;
      link_q    <= link_d;
    end
  end

  // =====================================================================
  // read answer, one cycle after the request
  always_comb begin
    rsp_valid_d = i_req.valid;
    rsp_rdata_d = 16'h0000;
    err_clear   = 1'b0;
    if (i_req.valid && !i_req.write) begin
      if (i_req.link) begin
        if (i_req.addr == `UCE_OFS_LINK) begin
          rsp_rdata_d = link_q;
        end
      end else if (i_req.addr == `UCE_OFS_ENABLE) begin
        rsp_rdata_d[1:0] = enable_q;
      end else if (i_req.addr == `UCE_OFS_FLOW) begin
        rsp_rdata_d[3:0] = flow_q;
      end else if (i_req.addr == `UCE_OFS_RESUME) begin
        rsp_rdata_d[7:0] = resume_q;
      end else if (i_req.addr == `UCE_OFS_SUSPEND) begin
        rsp_rdata_d[7:0] = suspend_q;
      end else if (i_req.addr == `UCE_OFS_ERR) begin
        rsp_rdata_d[`UCE_ERR_BRK_NOW] = i_rx_break;
        rsp_rdata_d[`UCE_ERR_OVR_BIT] = err_flags[3];
        rsp_rdata_d[`UCE_ERR_PAR_BIT] = err_flags[2];
        rsp_rdata_d[`UCE_ERR_FRM_BIT] = err_flags[1];
        rsp_rdata_d[`UCE_ERR_BRK_BIT] = err_flags[0];
        err_clear = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 16'h0000;
    end else begin
      rsp_valid_q <= rsp_valid_d;
      rsp_rdata_q <= rsp_rdata_d;
    end
  end

  // =====================================================================
  // receive path: blanking, flow characters, address matching
  logic [2:0]     mode;
  logic           rx_live;
  logic           is_adr;
  logic           adr_hit;
  logic           md_mode;
  logic           sw_mode;
  logic           is_flow_chr;
  logic           want_push;
  uce_txgate_type txg_q, txg_d;
  uce_adr_type    adr_q, adr_d;
  logic           push_q, push_d;
  logic [8:0]     rxd_q, rxd_d;
  logic           tx_allow_q, tx_allow_d;

  always_comb begin
    mode    = flow_q[2:0];
    sw_mode = (mode == `UCE_MODE_SW);
    md_mode = (mode == `UCE_MODE_MD_RX) || (mode == `UCE_MODE_MD_ALL);
    // half duplex: anything heard while sending is our own echo
    rx_live = enable_q[`UCE_EN_RX_BIT] && i_rx.valid &&
              !(flow_q[`UCE_FLOW_HDX_BIT] && i_tx_busy);
    is_adr  = md_mode && i_rx.data[`UCE_CHAR_ADR_BIT];
    adr_hit = (i_rx.data[7:0] == resume_q) ||
              (i_rx.data[7:0] == suspend_q);
    is_flow_chr = sw_mode && (char_match(i_rx.data, resume_q) ||
                              char_match(i_rx.data, suspend_q));
    txg_d = txg_q;
    adr_d = adr_q;
    if (!sw_mode) begin
      txg_d = TXG_RUN;
    end else if (rx_live) begin
      case (txg_q)
        TXG_RUN: begin
          if (char_match(i_rx.data, suspend_q)) begin
            txg_d = TXG_HELD;
          end
        end
        TXG_HELD: begin
          if (char_match(i_rx.data, resume_q)) begin
            txg_d = TXG_RUN;
          end
        end
        default: begin
          txg_d = TXG_RUN;
        end
      endcase
    end
    if (!md_mode) begin
      adr_d = ADR_OFF;
    end else if (rx_live && is_adr) begin
      case (adr_q)
        ADR_OFF: begin
          adr_d = adr_hit ? ADR_ON : ADR_OFF;
        end
        ADR_ON: begin
          adr_d = adr_hit ? ADR_ON : ADR_OFF;
        end
        default: begin
          adr_d = ADR_OFF;
        end
      endcase
    end
    // flow and address characters are consumed, never stored
    want_push = rx_live && !is_flow_chr && !is_adr &&
                (!md_mode || (adr_q == ADR_ON));
    push_d = want_push && !i_rx_fifo_full;
    rxd_d  = want_push ? i_rx.data : rxd_q;
    tx_allow_d = enable_q[`UCE_EN_TX_BIT] && (txg_d == TXG_RUN) &&
                 ((mode != `UCE_MODE_MD_ALL) || (adr_d == ADR_ON));
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      txg_q      <= TXG_RUN;
      adr_q      <= ADR_OFF;
      push_q     <= 1'b0;
      rxd_q      <= 9'h000;
      tx_allow_q <= 1'b0;
    end else begin
      txg_q      <= txg_d;
      adr_q      <= adr_d;
      push_q     <= push_d;
      rxd_q      <= rxd_d;
      tx_allow_q <= tx_allow_d;
    end
  end

  // =====================================================================
  // error accumulation
  uce_err_flags u_err (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ovr_evt  (want_push && i_rx_fifo_full),
    .i_par_evt  (rx_live && i_rx.parity_err),
    .i_frm_evt  (rx_live && i_rx.frame_err),
    .i_brk_now  (i_rx_break),
    .i_clear    (err_clear),
    .o_flags    (err_flags)
  );

  // =====================================================================
  // outputs
  assign o_rsp_valid   = rsp_valid_q;
  assign o_rsp_rdata   = rsp_rdata_q;
  assign o_tx_en       = enable_q[`UCE_EN_TX_BIT];
  assign o_rx_en       = enable_q[`UCE_EN_RX_BIT];
  assign o_half_duplex = flow_q[`UCE_FLOW_HDX_BIT];
  // the handshake pair itself is picked by the pin mode logic outside
  assign o_hw_flow_en  = (flow_q[2:0] == `UCE_MODE_HW);
  assign o_tx_allow    = tx_allow_q;
  assign o_rx_push     = push_q;
  assign o_rx_data     = rxd_q;
  assign o_link_state  = link_q;

  // =====================================================================
  // checks
  sequence s_err_read;
    reg_hit(i_req, `UCE_OFS_ERR) && !i_req.write;
  endsequence

  AST_ENABLE_WRITE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (reg_hit(i_req, `UCE_OFS_ENABLE) && i_req.write) |=>
      (o_rx_en == $past(i_req.wdata[1])) && (o_tx_en == $past(i_req.wdata[0])))
    else $error("enable bits not taken from write");

  AST_HDX_BLANK: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (flow_q[`UCE_FLOW_HDX_BIT] && i_tx_busy && i_rx.valid) |=> !o_rx_push)
    else $error("receive data accepted while transmitting in half duplex");

  AST_SW_SUSPEND: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (sw_mode && rx_live && char_match(i_rx.data, suspend_q)) |=> ##[0:1] !o_tx_allow)
    else $error("transmit not suspended after suspend character");

  AST_SW_RESUME: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (sw_mode && rx_live && char_match(i_rx.data, resume_q) && !char_match(i_rx.data, suspend_q)
     && o_tx_en && !i_req.valid) |=> (txg_q == TXG_RUN) && o_tx_allow)
    else $error("transmit not resumed after resume character");

  AST_NINE_BIT: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (sw_mode && rx_live && i_rx.data[`UCE_CHAR_ADR_BIT] && !i_req.valid) |=> $stable(txg_q))
    else $error("nine-bit character treated as flow character");

  AST_MD_GATE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (md_mode && (adr_q == ADR_OFF) && i_rx.valid && !i_rx.data[`UCE_CHAR_ADR_BIT]) |=> !o_rx_push)
    else $error("data received before address match");

  AST_UNICAST: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (rx_live && is_adr && (i_rx.data[7:0] == resume_q) && !i_req.valid) |=> (adr_q == ADR_ON))
    else $error("unicast address did not match");

  AST_MULTICAST: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (rx_live && is_adr && (i_rx.data[7:0] == suspend_q) && !i_req.valid) |=> (adr_q == ADR_ON))
    else $error("multicast address did not match");

  AST_BRK_NOW: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_err_read |=> o_rsp_valid && (o_rsp_rdata[`UCE_ERR_BRK_NOW] == $past(i_rx_break)))
    else $error("break-present bit does not follow the line");

  AST_PARITY_REPORT: assert property (@(posedge i_core_clk) disable iff (i_rst)
    // a read in between would take the flag first
    (rx_live && i_rx.parity_err) ##1 !err_clear ##1 s_err_read |=> o_rsp_rdata[`UCE_ERR_PAR_BIT])
    else $error("parity error not reported");

endmodule

// ### uce_err_flags.sv
// sticky receive error flags, cleared by a read of the status register
// assumes event inputs are single-cycle pulses on the core clock
`timescale 1ns/1ps
`include "uce_params.svh"

module uce_err_flags
  import uce_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ovr_evt,
  input  wire logic       i_par_evt,
  input  wire logic       i_frm_evt,
  input  wire logic       i_brk_now,
  input  wire logic       i_clear,
  output logic [3:0]      o_flags
);

  // order: overrun, parity, framing, break
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [3:0] evt;

  // =====================================================================
  // accumulate; a same-cycle event survives the read clear
  always_comb begin
    evt     = {i_ovr_evt, i_par_evt, i_frm_evt, i_brk_now};
    flags_d = (flags_q & ~{4{i_clear}}) | evt;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      flags_q <= `UCE_RST_ERR;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign o_flags = flags_q;

  // =====================================================================
  // checks
  AST_EVT_SURVIVES: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clear && (evt != 4'h0)) |=> ((o_flags & $past(evt)) == $past(evt)))
    else $error("error event lost on read clear");

  AST_READ_CLEARS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clear && (evt == 4'h0)) |=> (o_flags == 4'h0))
    else $error("error flags not cleared by read");

  AST_FLAG_STICKY: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_flags[3] && !i_clear) |=> o_flags[3])
    else $error("overrun flag dropped without read");

endmodule

// ### uce_params.svh
// named offsets, reset values, field positions and mode codes
// assumes inclusion by the bench and the design modules
`ifndef UCE_PARAMS_SVH
`define UCE_PARAMS_SVH

// =====================================================================
// register offsets (vendor request address)
`define UCE_OFS_ENABLE   12'h000
`define UCE_OFS_FLOW     12'h006
`define UCE_OFS_RESUME   12'h007
`define UCE_OFS_SUSPEND  12'h008
`define UCE_OFS_ERR      12'h009
`define UCE_OFS_LINK     12'h262

// =====================================================================
// reset values
`define UCE_RST_ENABLE   2'h0
`define UCE_RST_FLOW     4'h0
`define UCE_RST_RESUME   8'h11
`define UCE_RST_SUSPEND  8'h13
`define UCE_RST_LINK     16'h0000
`define UCE_RST_ERR      4'h0

// =====================================================================
// field positions
`define UCE_EN_TX_BIT    0
`define UCE_EN_RX_BIT    1
`define UCE_FLOW_HDX_BIT 3
`define UCE_ERR_BRK_NOW  7
`define UCE_ERR_OVR_BIT  6
`define UCE_ERR_PAR_BIT  5
`define UCE_ERR_FRM_BIT  4
`define UCE_ERR_BRK_BIT  3
`define UCE_CHAR_ADR_BIT 8

// =====================================================================
// flow mode codes
`define UCE_MODE_NONE    3'h0
`define UCE_MODE_HW      3'h1
`define UCE_MODE_SW      3'h2
`define UCE_MODE_MD_RX   3'h3
`define UCE_MODE_MD_ALL  3'h4

`endif

// ### uce_pkg.sv
// types shared by the uart control and error-status modules
// assumes uce_params.svh on the include path
package uce_pkg;

  // =====================================================================
  // vendor control request and received character carriers
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        link;
    logic [11:0] addr;
    logic [15:0] wdata;
  } uce_req_type;

  typedef struct packed {
    logic       valid;
    logic [8:0] data;
    logic       parity_err;
    logic       frame_err;
  } uce_rx_char_type;

  // =====================================================================
  // state encodings
  typedef enum logic [1:0] {
    TXG_RUN  = 2'b01,
    TXG_HELD = 2'b10
  } uce_txgate_type;

  typedef enum logic [1:0] {
    ADR_OFF = 2'b01,
    ADR_ON  = 2'b10
  } uce_adr_type;

endpackage

// ### uce_remote_dev.sv
// remote serial device: hands received characters and break level to the block
// assumes it shares the core clock with the control block
`timescale 1ns/1ps

module uce_remote_dev
  import uce_pkg::*;
(
  input  wire logic       i_core_clk,
  output uce_rx_char_type o_rx,
  output logic            o_rx_break
);
  initial begin
    o_rx       = '0;
    o_rx_break = 1'b0;
  end

  // =====================================================================
  // one character per call, valid for a single edge
  task automatic send(input logic [8:0] d, input logic pe, input logic fe);
    @(posedge i_core_clk);
    #1 o_rx = '{valid: 1'b1, data: d, parity_err: pe, frame_err: fe};
    @(posedge i_core_clk);
    // released lines must not keep showing the last character
    #1 o_rx = '{valid: 1'b0, data: ~d, parity_err: ~pe, frame_err: ~fe};
  endtask

  task automatic set_break(input logic b);
    @(posedge i_core_clk);
    #1 o_rx_break = b;
  endtask
endmodule
